// File: logic/slm_pkg.sv
// Package for the supply low-voltage monitor: register map, field layout,
// reset values, bus answers and timing constants.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package slm_pkg;

	// ****************************************************************
	// Bus geometry and answers
	// ****************************************************************
	localparam int SLM_ADDR_W = 8;
	localparam int SLM_DATA_W = 32;

	typedef enum logic [1:0] {
		SLM_RESP_OKAY   = 2'h0,
		SLM_RESP_SLVERR = 2'h2
	} slm_resp_t;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [SLM_ADDR_W-1:0] SLM_OFF_CTRL   = 8'h00;
	localparam logic [SLM_ADDR_W-1:0] SLM_OFF_MFG2   = 8'h04;
	localparam logic [SLM_ADDR_W-1:0] SLM_OFF_STATUS = 8'h08;
	localparam logic [SLM_ADDR_W-1:0] SLM_OFF_MASK   = 8'h0C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int SLM_CTRL_LEVEL_LSB = 0;
	localparam int SLM_CTRL_LEVEL_W   = 3;
	localparam int SLM_CTRL_ENABLE    = 4;
	localparam int SLM_CTRL_FLAG      = 5;
	localparam int SLM_MFG2_IRQ_EN    = 0;
	localparam int SLM_MFG2_IRQ_FLAG  = 4;
	localparam int SLM_EVT_W          = 2;
	localparam int SLM_EVT_REQUEST    = 0;
	localparam int SLM_EVT_LOW_RISE   = 1;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [SLM_CTRL_LEVEL_W-1:0] SLM_RST_LEVEL = 3'h0;
	localparam logic                        SLM_RST_BIT   = 1'b0;
	localparam logic [SLM_EVT_W-1:0]        SLM_RST_EVT   = 2'h0;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SLM_CLK_MHZ         = 25;
	localparam int SLM_IRQ_DELAY_US    = 15;
	localparam int SLM_IRQ_DELAY_CYC   = SLM_IRQ_DELAY_US * SLM_CLK_MHZ;

endpackage

// File: logic/slm_det_if.sv
// Interface between the register side and the detector datapath.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface slm_det_if;
	logic active;
	logic flag;
	logic irq_set;

	modport ctl (output active, input flag, input irq_set);
	modport det (input active, output flag, output irq_set);
endinterface

// File: logic/slm_detect.sv
// Detector datapath: comparator synchroniser, output flag, request delay.
// Assumes the comparator output is asynchronous to the system clock.
`timescale 1ns/1ps
module slm_detect
	import slm_pkg::*;
#(
	parameter int DELAY_CYCLES = SLM_IRQ_DELAY_CYC
) (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Analog comparator, high while supply is below the trip level
	input  wire logic comparator_low,
	// Register side
	slm_det_if.det    det
);
	localparam int CNT_W = $clog2(DELAY_CYCLES + 1);

	logic             sync_a;
	logic             sync_b;
	logic [CNT_W-1:0] cnt;
	logic             fired;
	wire              at_end = (cnt == CNT_W'(DELAY_CYCLES - 1));

	// ****************************************************************
	// Synchroniser and output flag
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a   <= 1'b0;
			sync_b   <= 1'b0;
			det.flag <= 1'b0;
		end else begin
			sync_a   <= comparator_low;
			sync_b   <= sync_a;
			det.flag <= det.active & sync_b; // R2 R11
		end
	end

	// ****************************************************************
	// Request delay, once per low-supply episode
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt         <= '0;
			fired       <= 1'b0;
			det.irq_set <= 1'b0;
		end else if (!det.flag) begin
			cnt         <= '0;
			fired       <= 1'b0;
			det.irq_set <= 1'b0;
		end else begin
			cnt         <= fired ? cnt : cnt + CNT_W'(1);
			fired       <= fired | at_end;
			det.irq_set <= !fired && at_end; // R7
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_flag_follows: assert property (det.active && sync_b |=> det.flag) // R2
		else $error("flag did not follow comparator");
	a_delay_exact: assert property (det.irq_set |-> cnt == CNT_W'(DELAY_CYCLES) && $past(det.flag)) // R7
		else $error("request raised before delay elapsed");
	a_flag_off: assert property (!det.active |=> !det.flag) // R4
		else $error("flag set while detector off");
endmodule

// File: logic/slm_top.sv
// Supply low-voltage monitor: AXI4-Lite register file, interrupt group
// bits, sticky event status and outputs to the analog comparator.
// Assumes comparator_low is asynchronous; sleep_mode and idle_mode come
// from the power controller on aclk.
//
// Functional notes
// R1: Bits 2..0 of the control register pick one of eight trip levels, 1.8 V to 4.0 V.
// R2: The undervoltage flag is high while the comparator sees supply below the level.
// R3: The undervoltage flag is bit 5 of the control register and writes cannot change it.
// R4: Bit 4 of the control register powers the comparator on when 1 and off when 0.
// R5: In sleep mode the detector is off whatever the enable bit holds.
// R6: Software waits for the detector to settle after enabling before trusting the flag.
// R7: The request flag is set only after a fixed delay of the flag staying high.
// R8: The detector request is one source of the shared multi-function interrupt.
// R9: Setting the request flag wakes the device out of idle mode.
// R10: Software sets the request flag beforehand if it does not want idle wake-up.
// R11: Every comparator transition passes through with no added hysteresis.
// R12: Control bits 7, 6 and 3 read as zero and ignore writes.
// R13: The request flag is bit 4 of the group-two register, 1 meaning pending.
// R14: Software clears the request flag when servicing; hardware never clears it.
// R15: The multi-function request is forwarded only while flag and its enable are both 1.
`timescale 1ns/1ps
module slm_top
	import slm_pkg::*;
#(
	parameter int DELAY_CYCLES = SLM_IRQ_DELAY_CYC
) (
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic                  awvalid,
	output      logic                  awready,
	input  wire logic [SLM_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]            awprot,
	// AXI4-Lite write data
	input  wire logic                  wvalid,
	output      logic                  wready,
	input  wire logic [SLM_DATA_W-1:0] wdata,
	input  wire logic [3:0]            wstrb,
	// AXI4-Lite write response
	output      logic                  bvalid,
	input  wire logic                  bready,
	output      logic [1:0]            bresp,
	// AXI4-Lite read address
	input  wire logic                  arvalid,
	output      logic                  arready,
	input  wire logic [SLM_ADDR_W-1:0] araddr,
	input  wire logic [2:0]            arprot,
	// AXI4-Lite read data
	output      logic                  rvalid,
	input  wire logic                  rready,
	output      logic [SLM_DATA_W-1:0] rdata,
	output      logic [1:0]            rresp,
	// Analog comparator
	input  wire logic                  comparator_low,
	output      logic                  comparator_enable,
	output      logic [2:0]            trip_level_select,
	// Power modes and interrupts
	input  wire logic                  sleep_mode,
	input  wire logic                  idle_mode,
	output      logic                  idle_wake,
	output      logic                  mf_request,
	output      logic                  irq
);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic                        monitor_enable;
	logic [SLM_CTRL_LEVEL_W-1:0] trip_level;
	logic                        monitor_irq_flag;
	logic                        monitor_irq_enable;
	logic [SLM_EVT_W-1:0]        status;
	logic [SLM_EVT_W-1:0]        mask;
	logic                        flag_prev;

	logic                  aw_held;
	logic                  w_held;
	logic [SLM_ADDR_W-1:0] wr_addr;
	logic [SLM_DATA_W-1:0] wr_data;
	logic                  wr_lane0;

	slm_det_if det_if ();

	// ****************************************************************
	// Detector datapath
	// ****************************************************************
	slm_detect #(
		.DELAY_CYCLES (DELAY_CYCLES)
	) u_detect (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.comparator_low (comparator_low),
		.det            (det_if.det)
	);

	assign det_if.active = comparator_enable; // R4 R5

	// ****************************************************************
	// Write channel handshake
	// ****************************************************************
	wire aw_fire     = awvalid & awready;
	wire w_fire      = wvalid & wready;
	wire do_write    = aw_held & w_held & ~bvalid;
	wire next_aw     = (aw_held & ~do_write) | aw_fire;
	wire next_w      = (w_held & ~do_write) | w_fire;
	wire next_bvalid = do_write | (bvalid & ~bready);

	wire wr_ctrl   = (wr_addr[SLM_ADDR_W-1:2] == SLM_OFF_CTRL[SLM_ADDR_W-1:2]);
	wire wr_mfg2   = (wr_addr[SLM_ADDR_W-1:2] == SLM_OFF_MFG2[SLM_ADDR_W-1:2]);
	wire wr_status = (wr_addr[SLM_ADDR_W-1:2] == SLM_OFF_STATUS[SLM_ADDR_W-1:2]);
	wire wr_mask   = (wr_addr[SLM_ADDR_W-1:2] == SLM_OFF_MASK[SLM_ADDR_W-1:2]);
	wire wr_hit    = wr_ctrl | wr_mfg2 | wr_status | wr_mask;
	wire wr_en     = do_write & wr_lane0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= SLM_RESP_OKAY;
			wr_addr  <= '0;
			wr_data  <= '0;
			wr_lane0 <= 1'b0;
		end else begin
			aw_held <= next_aw;
			w_held  <= next_w;
			awready <= ~next_aw;
			wready  <= ~next_w;
			bvalid  <= next_bvalid;
			if (aw_fire) begin
				wr_addr <= awaddr;
			end
			if (w_fire) begin
				wr_data  <= wdata;
				wr_lane0 <= wstrb[0];
			end
			if (do_write) begin
				bresp <= wr_hit ? SLM_RESP_OKAY : SLM_RESP_SLVERR;
			end
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	wire ar_fire     = arvalid & arready;
	wire next_rvalid = ar_fire | (rvalid & ~rready);

	wire rd_ctrl   = (araddr[SLM_ADDR_W-1:2] == SLM_OFF_CTRL[SLM_ADDR_W-1:2]);
	wire rd_mfg2   = (araddr[SLM_ADDR_W-1:2] == SLM_OFF_MFG2[SLM_ADDR_W-1:2]);
	wire rd_status = (araddr[SLM_ADDR_W-1:2] == SLM_OFF_STATUS[SLM_ADDR_W-1:2]);
	wire rd_mask   = (araddr[SLM_ADDR_W-1:2] == SLM_OFF_MASK[SLM_ADDR_W-1:2]);
	wire rd_hit    = rd_ctrl | rd_mfg2 | rd_status | rd_mask;

	// Flag is live state, enable and level are software state
	wire [7:0] ctrl_view = {2'h0, det_if.flag, monitor_enable, 1'b0, trip_level}; // R3 R12
	wire [7:0] mfg2_view = {3'h0, monitor_irq_flag, 3'h0, monitor_irq_enable}; // R13
	wire [7:0] rd_byte   = rd_ctrl   ? ctrl_view :
	                       rd_mfg2   ? mfg2_view :
	                       rd_status ? {6'h00, status} :
	                       rd_mask   ? {6'h00, mask} : 8'h00;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= SLM_RESP_OKAY;
		end else begin
			arready <= ~next_rvalid;
			rvalid  <= next_rvalid;
			if (ar_fire) begin
				rdata <= {24'h000000, rd_byte};
				rresp <= rd_hit ? SLM_RESP_OKAY : SLM_RESP_SLVERR;
			end
		end
	end

	// ****************************************************************
	// Control and group-two registers
	// ****************************************************************
	// Hardware set wins over a software clear in the same cycle
	wire next_irq_flag = det_if.irq_set ? 1'b1 : // R7 R13
	                     (wr_en & wr_mfg2) ? wr_data[SLM_MFG2_IRQ_FLAG] : monitor_irq_flag; // R14

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			monitor_enable     <= SLM_RST_BIT;
			trip_level         <= SLM_RST_LEVEL;
			monitor_irq_flag   <= SLM_RST_BIT;
			monitor_irq_enable <= SLM_RST_BIT;
		end else begin
			if (wr_en && wr_ctrl) begin
				monitor_enable <= wr_data[SLM_CTRL_ENABLE]; // R4
				trip_level     <= wr_data[SLM_CTRL_LEVEL_LSB +: SLM_CTRL_LEVEL_W]; // R1
			end
			if (wr_en && wr_mfg2) begin
				monitor_irq_enable <= wr_data[SLM_MFG2_IRQ_EN];
			end
			monitor_irq_flag <= next_irq_flag;
		end
	end

	// ****************************************************************
	// Sticky event status, read clears
	// ****************************************************************
	wire [SLM_EVT_W-1:0] events;
	assign events[SLM_EVT_REQUEST]  = det_if.irq_set;
	assign events[SLM_EVT_LOW_RISE] = det_if.flag & ~flag_prev;

	wire                 rd_clear    = ar_fire & rd_status;
	wire [SLM_EVT_W-1:0] next_status = (rd_clear ? SLM_RST_EVT : status) | events;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status    <= SLM_RST_EVT;
			mask      <= SLM_RST_EVT;
			flag_prev <= 1'b0;
		end else begin
			status    <= next_status;
			flag_prev <= det_if.flag;
			if (wr_en && wr_mask) begin
				mask <= wr_data[SLM_EVT_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Wake only on a fresh set, so a flag set in advance suppresses it
	wire next_wake = det_if.irq_set & ~monitor_irq_flag & idle_mode; // R9 R10

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comparator_enable <= 1'b0;
			trip_level_select <= SLM_RST_LEVEL;
			idle_wake         <= 1'b0;
			mf_request        <= 1'b0;
			irq               <= 1'b0;
		end else begin
			comparator_enable <= monitor_enable & ~sleep_mode; // R4 R5
			trip_level_select <= trip_level; // R1
			idle_wake         <= next_wake; // R9
			mf_request        <= monitor_irq_flag & monitor_irq_enable; // R8 R15
			irq               <= |(status & mask);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_sleep_powers_down: assert property (sleep_mode |=> !comparator_enable) // R5
		else $error("comparator enabled during sleep");
	a_enable_follows: assert property (monitor_enable && !sleep_mode |=> comparator_enable) // R4
		else $error("comparator not enabled");
	a_level_driven: assert property (##1 trip_level_select == $past(trip_level)) // R1
		else $error("trip level not forwarded");
	a_request_sets_flag: assert property (det_if.irq_set |=> monitor_irq_flag) // R7
		else $error("request flag not set");
	a_flag_sticky: assert property (monitor_irq_flag && !(wr_en && wr_mfg2) |=> monitor_irq_flag) // R14
		else $error("request flag cleared by hardware");
	a_mf_gate: assert property (mf_request |-> $past(monitor_irq_flag) && $past(monitor_irq_enable)) // R15
		else $error("request forwarded without flag and enable");
	a_idle_wakes: assert property (det_if.irq_set && !monitor_irq_flag && idle_mode |=> idle_wake) // R9
		else $error("no wake from idle");
	a_no_wake_preset: assert property (det_if.irq_set && monitor_irq_flag |=> !idle_wake) // R10
		else $error("wake despite preset flag");
	a_ctrl_read_zero: assert property (ar_fire && rd_ctrl |=> rdata[7:6] == 2'h0 && !rdata[3]) // R12
		else $error("unimplemented control bits not zero");
	a_ctrl_read_flag: assert property (ar_fire && rd_ctrl |=> rdata[SLM_CTRL_FLAG] == $past(det_if.flag)) // R3
		else $error("control read lost undervoltage flag");
	a_status_irq: assert property (|(status & mask) |=> irq) // R8
		else $error("interrupt not raised");

	// ****************************************************************
	// Register and output assertions
	// ****************************************************************
	a_level_write: assert property (wr_en && wr_ctrl |=> // R1
		trip_level == $past(wr_data[SLM_CTRL_LEVEL_LSB +: SLM_CTRL_LEVEL_W]))
		else $error("trip level write lost");
	a_enable_write: assert property (wr_en && wr_ctrl |=> monitor_enable == $past(wr_data[SLM_CTRL_ENABLE])) // R4
		else $error("enable bit write lost");
	a_disable_follows: assert property (!monitor_enable |=> !comparator_enable) // R4
		else $error("comparator enabled while monitor off");
	a_mfg2_read_flag: assert property (ar_fire && rd_mfg2 |=> // R13
		rdata[SLM_MFG2_IRQ_FLAG] == $past(monitor_irq_flag))
		else $error("group-two read lost request flag");
	a_flag_sw_clear: assert property (wr_en && wr_mfg2 && !wr_data[SLM_MFG2_IRQ_FLAG] && !det_if.irq_set |=> // R14
		!monitor_irq_flag)
		else $error("software clear of request flag lost");
	a_flag_only_set: assert property (!monitor_irq_flag && !det_if.irq_set && !(wr_en && wr_mfg2) |=> // R7
		!monitor_irq_flag)
		else $error("request flag set without a request");
	a_mf_raise: assert property (monitor_irq_flag && monitor_irq_enable |=> mf_request) // R15
		else $error("request not forwarded");
	a_irq_needs_mask: assert property (irq |-> $past(|(status & mask))) // R8
		else $error("interrupt without unmasked status");
	a_wake_cause: assert property (idle_wake |-> $past(det_if.irq_set && idle_mode && !monitor_irq_flag)) // R9
		else $error("wake without a fresh request in idle");

endmodule

// File: sim/slm_comparator_model.sv
// Behavioural supply comparator standing beside the monitor.
// Assumes the bench drives supply_mv in millivolts on aclk.
`timescale 1ns/1ps
module slm_comparator_model (
	// Clock
	input  wire logic        aclk,
	// Supply from the bench, control from the monitor
	input  wire logic [15:0] supply_mv,
	input  wire logic        enable,
	input  wire logic [2:0]  level,
	// High while enabled and the supply is below the trip level
	output      logic        low
);
	// Trip levels 1.8, 2.0, 2.4, 2.7, 3.0, 3.3, 3.6, 4.0 V in millivolts
	localparam logic [15:0] TRIP_MV [8] = '{16'h0708, 16'h07D0, 16'h0960, 16'h0A8C,
		16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
	logic state = 1'b0;

	// Powered down: the output wanders instead of holding its last value
	always @(posedge aclk) begin
		if (enable) begin
			state <= (supply_mv < TRIP_MV[level]);
		end else begin
			state <= ~state;
		end
	end
	assign low = state;
endmodule

// File: sim/test_supply_low_voltage_monitor.sv
// Directed testbench for the supply low-voltage monitor over AXI4-Lite.
// Assumes slm_top, its package and the comparator model are compiled first.
`timescale 1ns/1ps
module test_supply_low_voltage_monitor;
	import slm_pkg::*;
	localparam int          DLY   = 4;
	localparam logic [15:0] MV_OK = 16'h1388;
	localparam logic [15:0] MV_LO = 16'h0BB8;
	localparam logic [15:0] TRIP_MV [8] = '{16'h0708, 16'h07D0, 16'h0960, 16'h0A8C,
		16'h0BB8, 16'h0CE4, 16'h0E10, 16'h0FA0};
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rd_data;
	logic [3:0]  wstrb = 4'h0;
	logic [1:0]  bresp, rresp, last_resp;
	logic        comparator_low, comparator_enable, idle_wake, mf_request, irq;
	logic [2:0]  trip_level_select;
	logic        sleep_mode = 1'b0, idle_mode = 1'b0;
	logic [15:0] supply_mv = 16'h1388;
	int          n_errors = 0, checks_done = 0, wake_cnt = 0, i;

	always #20 aclk = ~aclk;

	slm_top #(.DELAY_CYCLES(DLY)) dut (.*, .awprot(3'h0), .arprot(3'h0));
	slm_comparator_model cmp (.aclk(aclk), .supply_mv(supply_mv), .enable(comparator_enable),
		.level(trip_level_select), .low(comparator_low));

	always @(posedge aclk) begin
		if (idle_wake === 1'b1) begin
			wake_cnt <= wake_cnt + 1;
		end
	end

	// ****************************************************************
	// Bus tasks and reporting
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		last_resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd_data = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask

	// Low supply for n cycles at the 4.0 V level, then settle
	task automatic episode(input int n);
		@(posedge aclk);
		supply_mv <= MV_LO;
		repeat (n) @(posedge aclk);
		supply_mv <= MV_OK;
		repeat (8) @(posedge aclk);
	endtask

	task report_and_stop;
		$display("errors %0d, checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		report_and_stop;
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SLM_OFF_CTRL);
		check(rd_data, 32'h0);
		check(comparator_enable, 1'b0);
		rd(SLM_OFF_MFG2);
		check(rd_data, 32'h0);
		wr(SLM_OFF_CTRL, 32'hFF, 4'hF);
		repeat (8) @(posedge aclk);
		rd(SLM_OFF_CTRL);
		check(rd_data, 32'h17);
		check(trip_level_select, 3'h7);
		check(comparator_enable, 1'b1);
		wr(SLM_OFF_MFG2, 32'h01, 4'h0);
		rd(SLM_OFF_MFG2);
		check(rd_data, 32'h0);
		wr(8'h10, 32'hFF, 4'hF);
		check(last_resp, SLM_RESP_SLVERR);
		rd(8'h10);
		check(rd_data, 32'h0);
		check(last_resp, SLM_RESP_SLVERR);
		wr(SLM_OFF_MASK, 32'h03, 4'hF);
		rd(SLM_OFF_STATUS);
		for (int l = 0; l < 8; l++) begin
			wr(SLM_OFF_CTRL, 32'h10 | l, 4'hF);
			supply_mv <= TRIP_MV[l] - 16'h1;
			repeat (8) @(posedge aclk);
			rd(SLM_OFF_CTRL);
			check(rd_data, 32'h30 | l);
			check(trip_level_select, l[2:0]);
			supply_mv <= TRIP_MV[l];
			repeat (8) @(posedge aclk);
			rd(SLM_OFF_CTRL);
			check(rd_data, 32'h10 | l);
		end
		check(irq, 1'b1);
		rd(SLM_OFF_STATUS);
		check(rd_data, 32'h3);
		@(posedge aclk);
		check(irq, 1'b0);
		rd(SLM_OFF_MFG2);
		check(rd_data, 32'h10);
		check(mf_request, 1'b0);
		wr(SLM_OFF_MFG2, 32'h11, 4'hF);
		repeat (2) @(posedge aclk);
		check(mf_request, 1'b1);
		wr(SLM_OFF_MFG2, 32'h01, 4'hF);
		repeat (2) @(posedge aclk);
		check(mf_request, 1'b0);
		rd(SLM_OFF_MFG2);
		check(rd_data, 32'h01);
		sleep_mode <= 1'b1;
		supply_mv <= MV_LO;
		repeat (8) @(posedge aclk);
		check(comparator_enable, 1'b0);
		rd(SLM_OFF_CTRL);
		check(rd_data, 32'h17);
		supply_mv <= MV_OK;
		sleep_mode <= 1'b0;
		repeat (8) @(posedge aclk);
		wr(SLM_OFF_MASK, 32'h0, 4'hF);
		rd(SLM_OFF_STATUS);
		@(posedge aclk);
		supply_mv <= MV_LO;
		i = 0;
		while (mf_request !== 1'b1 && i < 40) begin
			@(posedge aclk);
			i++;
		end
		check(i > DLY, 1'b1);
		check(i, DLY + 7);
		check(mf_request, 1'b1);
		check(irq, 1'b0);
		supply_mv <= MV_OK;
		wr(SLM_OFF_MFG2, 32'h01, 4'hF);
		rd(SLM_OFF_STATUS);
		episode(2);
		rd(SLM_OFF_MFG2);
		check(rd_data, 32'h01);
		rd(SLM_OFF_STATUS);
		check(rd_data, 32'h2);
		idle_mode <= 1'b1;
		episode(12);
		check(wake_cnt, 1);
		wr(SLM_OFF_MFG2, 32'h11, 4'hF);
		episode(12);
		check(wake_cnt, 1);
		check(mf_request, 1'b1);
		wr(SLM_OFF_STATUS, 32'h0, 4'hF);
		check(last_resp, SLM_RESP_OKAY);
		rd(SLM_OFF_STATUS);
		check(rd_data, 32'h3);
		report_and_stop;
	end
endmodule
